// >>> usc_pkg.sv
package usc_pkg;

    // ----------------------------------------
    // Register offsets, relative to the block base
    // ----------------------------------------
    localparam logic [19:0] OFF_CTRL = 20'h0_0000;
    localparam logic [19:0] OFF_STATUS = 20'h0_0004;
    localparam logic [19:0] OFF_IFLAG = 20'h0_0008;
    localparam logic [19:0] OFF_IFSET = 20'h0_000C;
    localparam logic [19:0] OFF_IFCLR = 20'h0_0010;
    localparam logic [19:0] OFF_IEN = 20'h0_0014;
    localparam logic [19:0] OFF_ROUTE = 20'h0_0018;
    localparam logic [19:0] OFF_RXPEEK = 20'h3_C01C;
    localparam logic [19:0] OFF_RXPOP = 20'h3_C020;
    localparam logic [19:0] OFF_PCGC = 20'h3_CE00;
    localparam logic [19:0] OFF_RAM_LO = 20'h5_C000;
    localparam logic [19:0] OFF_RAM_HI = 20'h5_C7FC;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_PUPOL = 1;
    localparam int BIT_OSC_LO = 4;
    localparam int BIT_PHYCTL = 7;
    localparam int BIT_LP_IDLE = 9;
    localparam int BIT_LP_NAK = 10;
    localparam int BIT_LP_ADDR = 11;
    localparam int BIT_VREGDIS = 16;
    localparam int BIT_SENSE_EN = 17;
    localparam int BIT_BIAS01 = 20;
    localparam int BIT_BIAS23 = 24;
    localparam int BIT_SENSE = 0;
    localparam int BIT_LP_ACT = 2;
    localparam int BIT_IF_HIGH = 0;
    localparam int BIT_IF_LOW = 1;
    localparam int BIT_PHY_PEN = 0;
    localparam int BIT_PU_PEN = 2;

    // ----------------------------------------
    // Reset values and masks
    // ----------------------------------------
    localparam logic [31:0] CTRL_MASK = 32'h0333_0EB2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
    localparam logic [31:0] IF_MASK = 32'h0000_0003;
    localparam logic [31:0] IF_RESET = 32'h0000_0003;
    localparam logic [31:0] ROUTE_MASK = 32'h0000_0005;
    localparam logic [31:0] PCGC_MASK = 32'h0000_000F;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    localparam logic [1:0] OSC_NONE = 2'h0;
    localparam logic [1:0] OSC_GATE = 2'h1;
    localparam logic [1:0] OSC_SUSPEND = 2'h2;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic addrMismatch;
        logic outNak;
        logic busIdle;
    } usc_lp_event_type;

    typedef struct packed {
        logic phyEnable;
        logic pullupEnable;
        logic pullupPin;
        logic phyLowPower;
        logic coreClockGate;
        logic fastRcSuspend;
    } usc_phy_ctl_type;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_RAM_RD,
        BUS_DONE
    } usc_bus_state_type;

endpackage

// >>> usc_rx_status_queue.sv
`timescale 1ns/100ps
module usc_rx_status_queue
    import usc_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Push from the core
    input wire logic pushValid,
    input wire logic [WIDTH-1:0] pushData,
    // Peek and pop
    input wire logic pop,
    output logic [WIDTH-1:0] top,
    output logic empty,
    output logic full
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] rdPtr;
    logic [AW-1:0] wrPtr;
    logic [AW:0] count;
    logic doPush;
    logic doPop;

    // Entries arriving while full are dropped
    assign doPush = pushValid && (count != (AW+1)'(DEPTH));
    assign doPop = pop && (count != '0);
    assign top = (count == '0) ? '0 : mem[rdPtr];
    assign empty = (count == '0);
    assign full = (count == (AW+1)'(DEPTH));

    always_ff @(posedge clock) begin
        if (doPush) begin
            mem[wrPtr] <= pushData;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdPtr <= '0;
            wrPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= AW'((wrPtr + 1'b1) % DEPTH);
            end
            if (doPop) begin
                rdPtr <= AW'((rdPtr + 1'b1) % DEPTH);
            end
            count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
endmodule

// >>> usc_system_regs.sv
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps
// Notes on behaviour
// - Offsets decode relative to block base
// - Control bit 17 enables regulator sensing
// - Bits 5:4 choose oscillator low-power behaviour
// - Bit 1 sets pull-up pin polarity
// - Flag-set writes of one set flags
// - Flag-clear writes of one clear flags
// - Pop read removes entry; peek does not
// - Debug RAM window 0x5C000 to 0x5C7FC
// - Power gating register at 0x3CE00
// - Status bit 2 shows low energy
// - Status bit 0 shows regulator above threshold
// - PHY pin enable routes pins, enables PHY
module usc_system_regs
    import usc_pkg::*;
#(
    parameter int RAM_WORDS = 512,
    parameter int RX_DEPTH = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [19:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Core and analog status
    input wire logic regulatorSenseRaw,
    input wire usc_lp_event_type lpEventRaw,
    input wire logic pullupRequest,
    input wire logic rxStatusValid,
    input wire logic [31:0] rxStatusData,
    input wire logic mainClockIsFastRc,
    // Control toward core, PHY and regulator
    output usc_phy_ctl_type phyCtl,
    output logic senseEnable,
    output logic regulatorDisable,
    output logic [3:0] pcgcOut
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [31:0] ctrl;
    logic [31:0] route;
    logic [31:0] ien;
    logic [31:0] pcgc;
    logic [1:0] iflag;
    logic [31:0] ram [RAM_WORDS];
    usc_bus_state_type state;
    logic [31:0] wmask;
    logic [31:0] rdMux;
    logic [31:0] ramWord;
    logic [8:0] ramIndex;
    logic rxPop;
    logic [31:0] rxTop;
    logic senseSync1;
    logic senseSync2;
    logic senseLevel;
    logic senseLast;
    logic senseEn1;
    logic senseEn2;
    usc_lp_event_type lpSync1;
    usc_lp_event_type lpSync2;
    logic lowPower;
    logic next_lowPower;
    logic accept;
    logic isRam;

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic in_ram(input logic [19:0] a);
        in_ram = (a >= OFF_RAM_LO) && (a <= OFF_RAM_HI);
    endfunction

    assign wmask = lane_mask(byteenable);
    assign isRam = in_ram(address);
    assign ramIndex = address[10:2];
    // One wait cycle per access, two for RAM reads, keeps waitrequest and readdata on flip-flops
    assign accept = (state == BUS_DONE);
    // Pop where the entry is captured, so a late push cannot be lost unread
    assign rxPop = read && (state == BUS_IDLE) && (address == OFF_RXPOP);

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= BUS_IDLE;
            waitrequest <= 1'b1;
        end else begin
            case (state)
                BUS_IDLE: begin
                    if (read && isRam) begin
                        state <= BUS_RAM_RD;
                    end else if (read || write) begin
                        state <= BUS_DONE;
                        waitrequest <= 1'b0;
                    end
                end
                BUS_RAM_RD: begin
                    state <= BUS_DONE;
                    waitrequest <= 1'b0;
                end
                default: begin
                    state <= BUS_IDLE;
                    waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    always_comb begin
        rdMux = UNMAPPED_DATA;
        if (address == OFF_CTRL) begin
            rdMux = ctrl;
        end else if (address == OFF_STATUS) begin
            rdMux = UNMAPPED_DATA;
            rdMux[BIT_LP_ACT] = lowPower;
            rdMux[BIT_SENSE] = senseLevel;
        end else if (address == OFF_IFLAG) begin
            rdMux = {30'h0, iflag};
        end else if (address == OFF_IEN) begin
            rdMux = ien;
        end else if (address == OFF_ROUTE) begin
            rdMux = route;
        end else if (address == OFF_RXPEEK || address == OFF_RXPOP) begin
            rdMux = rxTop;
        end else if (address == OFF_PCGC) begin
            rdMux = pcgc;
        end
    end

    always_ff @(posedge clock) begin
        if (state == BUS_IDLE && read && isRam) begin
            ramWord <= ram[ramIndex];
        end
    end

    always_ff @(posedge clock) begin
        if (accept && write && isRam) begin
            ram[ramIndex] <= (ram[ramIndex] & ~wmask) | (writedata & wmask);
        end
    end

    // Read data registered so the output comes from a flip-flop
    always_ff @(posedge clock) begin
        if (rst) begin
            readdata <= '0;
        end else if (state == BUS_IDLE && read && !isRam) begin
            readdata <= rdMux;
        end else if (state == BUS_RAM_RD) begin
            readdata <= ramWord;
        end
    end

    // ----------------------------------------
    // Writable registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl <= CTRL_RESET;
            route <= '0;
            ien <= '0;
            pcgc <= '0;
        end else if (accept && write) begin
            // Reserved bits masked off; software must write them as zero
            if (address == OFF_CTRL) begin
                ctrl <= (ctrl & ~wmask) | (writedata & wmask & CTRL_MASK);
            end else if (address == OFF_IEN) begin
                ien <= (ien & ~wmask) | (writedata & wmask & IF_MASK);
            end else if (address == OFF_ROUTE) begin
                route <= (route & ~wmask) | (writedata & wmask & ROUTE_MASK);
            end else if (address == OFF_PCGC) begin
                pcgc <= (pcgc & ~wmask) | (writedata & wmask & PCGC_MASK);
            end
        end
    end

    // ----------------------------------------
    // Sensing and interrupt flags
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            senseSync1 <= 1'b0;
            senseSync2 <= 1'b0;
            lpSync1 <= '0;
            lpSync2 <= '0;
        end else begin
            senseSync1 <= regulatorSenseRaw;
            senseSync2 <= senseSync1;
            lpSync1 <= lpEventRaw;
            lpSync2 <= lpSync1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            senseLevel <= 1'b0;
            senseLast <= 1'b0;
            senseEn1 <= 1'b0;
            senseEn2 <= 1'b0;
        end else begin
            // Unpowered comparator output is junk; trust it only once the
            // enable has crossed the same two stages, else false edges flag
            senseEn1 <= senseEnable;
            senseEn2 <= senseEn1;
            senseLevel <= ctrl[BIT_SENSE_EN] & senseEn2 & senseSync2;
            senseLast <= senseLevel;
        end
    end

    // Hardware and set-register events win over a simultaneous clear
    always_ff @(posedge clock) begin
        logic [1:0] setv;
        logic [1:0] clrv;
        setv = {senseLast & ~senseLevel, ~senseLast & senseLevel};
        clrv = '0;
        if (accept && write && byteenable[0]) begin
            if (address == OFF_IFSET) begin
                setv = setv | writedata[1:0];
            end else if (address == OFF_IFCLR) begin
                clrv = writedata[1:0];
            end
        end
        if (rst) begin
            iflag <= IF_RESET[1:0];
        end else begin
            iflag <= (iflag & ~clrv) | setv;
        end
    end

    // ----------------------------------------
    // Low energy mode
    // ----------------------------------------
    always_comb begin
        next_lowPower = (ctrl[BIT_LP_ADDR] & lpSync2.addrMismatch)
            | (ctrl[BIT_LP_NAK] & lpSync2.outNak)
            | (ctrl[BIT_LP_IDLE] & lpSync2.busIdle);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            lowPower <= 1'b0;
        end else begin
            lowPower <= next_lowPower;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge clock) begin
        logic [1:0] osc;
        osc = ctrl[BIT_OSC_LO +: 2];
        if (rst) begin
            phyCtl <= '0;
            senseEnable <= 1'b0;
            regulatorDisable <= 1'b0;
            pcgcOut <= '0;
        end else begin
            phyCtl.phyEnable <= route[BIT_PHY_PEN];
            phyCtl.pullupEnable <= route[BIT_PU_PEN];
            phyCtl.pullupPin <= pullupRequest ^ ~ctrl[BIT_PUPOL];
            phyCtl.phyLowPower <= lowPower & ctrl[BIT_PHYCTL];
            phyCtl.coreClockGate <= lowPower
                & (osc == OSC_GATE || osc == OSC_SUSPEND);
            phyCtl.fastRcSuspend <= lowPower & (osc == OSC_SUSPEND)
                & ~mainClockIsFastRc;
            senseEnable <= ctrl[BIT_SENSE_EN];
            regulatorDisable <= ctrl[BIT_VREGDIS];
            pcgcOut <= pcgc[3:0];
        end
    end

    // ----------------------------------------
    // Receive status queue
    // ----------------------------------------
    usc_rx_status_queue #(
        .DEPTH(RX_DEPTH),
        .WIDTH(32)
    ) rxQueue (
        .clock(clock),
        .rst(rst),
        .pushValid(rxStatusValid),
        .pushData(rxStatusData),
        .pop(rxPop),
        .top(rxTop),
        .empty(),
        .full()
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_sense_gate: assert property (@(posedge clock) disable iff (rst)
        !ctrl[BIT_SENSE_EN] |=> !senseLevel)
        else $error("sense reads high while disabled");
    chk_osc_reset: assert property (@(posedge clock)
        rst |=> ctrl[BIT_OSC_LO +: 2] == OSC_SUSPEND)
        else $error("oscillator field reset wrong");
    chk_pullup_pol: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> phyCtl.pullupPin == ($past(pullupRequest) ^ ~$past(ctrl[BIT_PUPOL])))
        else $error("pull-up polarity wrong");
    chk_flag_set: assert property (@(posedge clock) disable iff (rst)
        (accept && write && byteenable[0] && address == OFF_IFSET
        && writedata[0]) |=> iflag[0])
        else $error("flag set lost");
    chk_flag_clear: assert property (@(posedge clock) disable iff (rst)
        (accept && write && byteenable[0] && address == OFF_IFCLR
        && writedata[1] && !(senseLast & ~senseLevel)) |=> !iflag[1])
        else $error("flag clear lost");
    chk_lp_status: assert property (@(posedge clock) disable iff (rst)
        (state == BUS_IDLE && read && address == OFF_STATUS)
        |=> readdata[BIT_LP_ACT] == $past(lowPower))
        else $error("status low energy bit wrong");
    chk_lp_enable: assert property (@(posedge clock) disable iff (rst)
        (ctrl[11:9] == 3'b000) [*2] |=> !lowPower)
        else $error("low energy entered while disabled");
    chk_phy_low: assert property (@(posedge clock) disable iff (rst)
        !ctrl[BIT_PHYCTL] |=> !phyCtl.phyLowPower)
        else $error("PHY lowered with control clear");
    chk_phy_route: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> phyCtl.phyEnable == $past(route[BIT_PHY_PEN]))
        else $error("PHY enable not following route");
    chk_ram_wait: assert property (@(posedge clock) disable iff (rst)
        (state == BUS_IDLE && read && isRam)
        |-> waitrequest ##1 waitrequest ##1 !waitrequest)
        else $error("RAM read timing wrong");

    cov_flag_set: cover property (@(posedge clock) disable iff (rst)
        state == BUS_IDLE && write && address == OFF_IFSET);
    cov_pop: cover property (@(posedge clock) disable iff (rst) rxPop);
    cov_lowpower: cover property (@(posedge clock) disable iff (rst) lowPower);
    cov_ram_rd: cover property (@(posedge clock) disable iff (rst) state == BUS_RAM_RD);
endmodule

// >>> usc_far_model.sv
`timescale 1ns/100ps
module usc_far_model
    import usc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Commands from the bench
    input wire logic vregoUp,
    input wire usc_lp_event_type lpCond,
    input wire logic pushStb,
    input wire logic [31:0] pushWord,
    // From the block
    input wire logic senseEnable,
    // Toward the block
    output logic regulatorSenseRaw,
    output usc_lp_event_type lpEventRaw,
    output logic rxStatusValid,
    output logic [31:0] rxStatusData
);
    logic toggle;

    // ----------------------------------------
    // Comparator and core events
    // ----------------------------------------
    // Unpowered comparator gives no level, so it chatters
    assign regulatorSenseRaw = senseEnable ? vregoUp : toggle;
    assign lpEventRaw = lpCond;

    // ----------------------------------------
    // Receive status pushes
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            toggle <= 1'b0;
            rxStatusValid <= 1'b0;
            rxStatusData <= 32'h0000_0000;
        end else begin
            toggle <= ~toggle;
            rxStatusValid <= pushStb;
            // Data outside a push is not held stable
            rxStatusData <= pushStb ? pushWord : ~rxStatusData;
        end
    end
endmodule

// >>> usc_system_regs_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin errorCnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module usc_system_regs_tb
    import usc_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [19:0] address = 20'h0_0000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic pullupRequest = 1'b0;
    logic mainClockIsFastRc = 1'b0;
    logic vregoUp = 1'b0;
    logic pushStb = 1'b0;
    logic [31:0] pushWord = 32'h0000_0000;
    usc_lp_event_type lpCond = '0;
    usc_lp_event_type lpEventRaw;
    usc_phy_ctl_type phyCtl;
    logic regulatorSenseRaw;
    logic rxStatusValid;
    logic [31:0] rxStatusData;
    logic senseEnable;
    logic regulatorDisable;
    logic [3:0] pcgcOut;
    logic [31:0] rd;
    logic [31:0] ctl;
    int errorCnt = 0;
    int cmpCount = 0;
    int enBit [3] = '{BIT_LP_ADDR, BIT_LP_NAK, BIT_LP_IDLE};

    always #5 clock = ~clock;

    usc_system_regs #(.RAM_WORDS(512), .RX_DEPTH(4)) dut_u (
        .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .regulatorSenseRaw(regulatorSenseRaw),
        .lpEventRaw(lpEventRaw), .pullupRequest(pullupRequest),
        .rxStatusValid(rxStatusValid), .rxStatusData(rxStatusData),
        .mainClockIsFastRc(mainClockIsFastRc), .phyCtl(phyCtl),
        .senseEnable(senseEnable), .regulatorDisable(regulatorDisable), .pcgcOut(pcgcOut)
    );

    usc_far_model far_u (
        .clock(clock), .rst(rst), .vregoUp(vregoUp), .lpCond(lpCond),
        .pushStb(pushStb), .pushWord(pushWord), .senseEnable(senseEnable),
        .regulatorSenseRaw(regulatorSenseRaw), .lpEventRaw(lpEventRaw),
        .rxStatusValid(rxStatusValid), .rxStatusData(rxStatusData)
    );

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    // Waitrequest and readdata leave flip-flops: mid-cycle values are what the
    // next rising edge samples, so that edge is the accept edge
    task automatic bus_acc(input logic isWrite, input logic [19:0] a, input logic [31:0] d,
                           input logic [3:0] be);
        logic w;
        @(posedge clock);
        address <= a;
        writedata <= d;
        byteenable <= be;
        read <= !isWrite;
        write <= isWrite;
        do begin
            @(negedge clock);
            w = waitrequest;
            rd = readdata;
            @(posedge clock);
        end while (w);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        bus_acc(1'b1, a, d, 4'hF);
    endtask

    task automatic rd_chk(input logic [19:0] a, input logic [31:0] e, input string nm);
        bus_acc(1'b0, a, 32'h0000_0000, 4'hF);
        `CHK(nm, e, rd)
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic push(input logic [31:0] d);
        @(posedge clock);
        pushStb <= 1'b1;
        pushWord <= d;
        @(posedge clock);
        pushStb <= 1'b0;
        tick(3);
    endtask

    task automatic wrap_up;
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd_chk(OFF_CTRL, CTRL_RESET, "ctrl reset");
        rd_chk(OFF_STATUS, 32'h0000_0000, "status reset");
        rd_chk(OFF_IFLAG, IF_RESET, "flag reset");
        rd_chk(OFF_IEN, 32'h0000_0000, "ien reset");
        rd_chk(OFF_ROUTE, 32'h0000_0000, "route reset");
        rd_chk(20'h0_001C, UNMAPPED_DATA, "unmapped");
        @(negedge clock);
        `CHK("pullup low idle", 1'b1, phyCtl.pullupPin)
        @(posedge clock);
        pullupRequest <= 1'b1;
        tick(2);
        @(negedge clock);
        `CHK("pullup low act", 1'b0, phyCtl.pullupPin)
        wr(OFF_CTRL, CTRL_MASK);
        tick(1);
        @(negedge clock);
        `CHK("pullup high act", 1'b1, phyCtl.pullupPin)
        `CHK("sense en out", 1'b1, senseEnable)
        `CHK("vreg dis out", 1'b1, regulatorDisable)
        rd_chk(OFF_CTRL, CTRL_MASK, "ctrl rw");
        bus_acc(1'b1, OFF_CTRL, 32'h0000_0000, 4'b0001);
        rd_chk(OFF_CTRL, CTRL_MASK & 32'hFFFF_FF00, "ctrl lane");
        wr(OFF_CTRL, CTRL_RESET);
        // Flag register access kinds
        wr(OFF_IFCLR, 32'h0000_0001);
        rd_chk(OFF_IFLAG, 32'h0000_0002, "clr one");
        wr(OFF_IFCLR, 32'h0000_0000);
        rd_chk(OFF_IFLAG, 32'h0000_0002, "clr zero");
        wr(OFF_IFLAG, 32'h0000_0000);
        rd_chk(OFF_IFLAG, 32'h0000_0002, "flag ro");
        wr(OFF_IFCLR, 32'h0000_0002);
        wr(OFF_IFSET, 32'h0000_0001);
        rd_chk(OFF_IFLAG, 32'h0000_0001, "set one");
        wr(OFF_IFSET, 32'h0000_0000);
        rd_chk(OFF_IFLAG, 32'h0000_0001, "set zero");
        wr(OFF_IFCLR, 32'h0000_0001);
        wr(OFF_IEN, IF_MASK);
        rd_chk(OFF_IEN, IF_MASK, "ien rw");
        // Regulator sensing
        vregoUp <= 1'b1;
        tick(6);
        rd_chk(OFF_STATUS, 32'h0000_0000, "sense off");
        wr(OFF_CTRL, CTRL_RESET | 32'h0002_0000);
        tick(6);
        rd_chk(OFF_STATUS, 32'h0000_0001, "sense high");
        rd_chk(OFF_IFLAG, 32'h0000_0001, "rise flag");
        vregoUp <= 1'b0;
        tick(6);
        rd_chk(OFF_STATUS, 32'h0000_0000, "sense low");
        rd_chk(OFF_IFLAG, 32'h0000_0003, "fall flag");
        // Low energy: each condition, oscillator mode and PHY control
        for (int k = 0; k < 3; k++) begin
            lpCond <= usc_lp_event_type'(3'b100 >> k);
            wr(OFF_CTRL, 32'h0000_0000);
            tick(6);
            rd_chk(OFF_STATUS, 32'h0000_0000, "lp disabled");
            ctl = (32'(k) << BIT_OSC_LO) | (32'h1 << enBit[k]);
            ctl = ctl | ((k == 1) ? (32'h1 << BIT_PHYCTL) : 32'h0);
            wr(OFF_CTRL, ctl);
            tick(6);
            rd_chk(OFF_STATUS, 32'h0000_0004, "lp active");
            `CHK("clk gate", k != 0, phyCtl.coreClockGate)
            `CHK("rc suspend", k == 2, phyCtl.fastRcSuspend)
            `CHK("phy lowpwr", k == 1, phyCtl.phyLowPower)
            if (k == 2) begin
                mainClockIsFastRc <= 1'b1;
                tick(4);
                `CHK("rc is main", 1'b0, phyCtl.fastRcSuspend)
            end
            lpCond <= '0;
            tick(6);
            rd_chk(OFF_STATUS, 32'h0000_0000, "lp left");
            `CHK("gate off", 1'b0, phyCtl.coreClockGate)
        end
        // Receive status queue
        push(32'hA5A5_0001);
        push(32'hA5A5_0002);
        rd_chk(OFF_RXPEEK, 32'hA5A5_0001, "peek");
        rd_chk(OFF_RXPEEK, 32'hA5A5_0001, "peek again");
        rd_chk(OFF_RXPOP, 32'hA5A5_0001, "pop");
        rd_chk(OFF_RXPEEK, 32'hA5A5_0002, "peek next");
        rd_chk(OFF_RXPOP, 32'hA5A5_0002, "pop next");
        // Debug RAM window edges and the word past it
        wr(OFF_RAM_LO, 32'h1234_5678);
        wr(OFF_RAM_HI, 32'h9ABC_DEF0);
        rd_chk(OFF_RAM_LO, 32'h1234_5678, "ram lo");
        rd_chk(OFF_RAM_HI, 32'h9ABC_DEF0, "ram hi");
        rd_chk(20'h5_C800, UNMAPPED_DATA, "ram past");
        // Power gating and routing
        wr(OFF_PCGC, PCGC_MASK);
        tick(1);
        @(negedge clock);
        `CHK("pcgc out", 4'hF, pcgcOut)
        rd_chk(OFF_PCGC, PCGC_MASK, "pcgc rd");
        wr(OFF_ROUTE, ROUTE_MASK);
        tick(1);
        @(negedge clock);
        `CHK("phy en", 1'b1, phyCtl.phyEnable)
        `CHK("pullup pin en", 1'b1, phyCtl.pullupEnable)
        rd_chk(OFF_ROUTE, ROUTE_MASK, "route rd");
        wrap_up;
    end

    // Whole run is a few hundred bus cycles
    initial begin
        repeat (20000) @(posedge clock);
        errorCnt++;
        wrap_up;
    end
endmodule
